// ### adc_conversion_sequencer.v
/*
 converter sequencer: control, result and interrupt-control registers over
 axi4-lite, conversion start/stop/abort, sleep handling and special trigger.
 assumes: comparator and sleep status arrive as asynchronous pins; trigger
 pulse comes from logic on aclk.
*/
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
// How it works
// - converter runs only while converter_on is one
// - writing one to go/done starts a conversion only if converter_on is already one
// - completion clears go/done, sets done flag, loads both result bytes
// - software clearing go/done aborts and stores the partial code
// - unresolved bits copy the last resolved bit
// - reset clears registers, converter off, conversion dropped
// - conversion continues in sleep only with the rc clock selected
// - rc clock delays conversion start by one instruction cycle
// - completion in sleep with irq enabled raises wake
// - completion in sleep with irq disabled powers off, converter_on stays
// - sleep with other clock during a conversion aborts and powers off, converter_on stays
// - special trigger with converter_on one and go/done zero sets go/done and clears the sixteen-bit timer
// - done flag sets whatever the enables are
// - irq reaches cpu only with all three enables set
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_conversion_sequencer #(
  parameter WIDTH = 10,
  parameter TAD   = `TAD_CYCLES_DEF
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        comp_in,
  input  wire        sleep_in,
  input  wire        special_trigger,
  output reg         powered,
  output reg  [4:0]  channel_select,
  output reg  [9:0]  dac_trial,
  output reg         irq,
  output reg         wake
);

  reg  [7:0]  control_0_reg;
  reg  [7:0]  control_1_reg;
  reg  [7:0]  result_high_byte_reg;
  reg  [7:0]  result_low_byte_reg;
  reg         done_flag_reg;
  reg         irq_en_reg;
  reg         periph_en_reg;
  reg         global_en_reg;
  reg  [15:0] timer_reg;
  reg         off_reg;
  reg  [3:0]  delay_reg;
  reg         pend_reg;
  reg  [2:0]  comp_sync_reg;
  reg         comp_reg;
  reg  [2:0]  sleep_sync_reg;
  reg         sleep_reg;
  reg  [7:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_have_reg;
  reg         w_have_reg;

  wire [WIDTH-1:0] trial;
  wire [WIDTH-1:0] code;
  wire             busy;
  wire             done;

  wire converter_on = control_0_reg[`BIT_CONVERTER_ON];
  wire go_done      = control_0_reg[`BIT_GO_DONE];
  wire [2:0] clksel = control_1_reg[`BIT_CLK_HI:`BIT_CLK_LO];
  wire rc_clock     = (clksel == `CLKSEL_RC) || (clksel == `CLKSEL_RC_ALT);
  wire active       = converter_on && !off_reg;

  function [31:0] reg_word;
    input [7:0] b;
    begin
      reg_word = {24'h000000, b};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparator and sleep status are asynchronous; a change counts once the
  // second and third stages agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      comp_sync_reg  <= 3'h0;
      comp_reg       <= 1'b0;
      sleep_sync_reg <= 3'h0;
      sleep_reg      <= 1'b0;
    end
    else if (ce)
    begin
      comp_sync_reg  <= {comp_sync_reg[1:0], comp_in};
      sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_in};
      if (comp_sync_reg[1] == comp_sync_reg[2])
        comp_reg <= comp_sync_reg[2];
      if (sleep_sync_reg[1] == sleep_sync_reg[2])
        sleep_reg <= sleep_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire aw_now = s_axi_awvalid && s_axi_awready;
  wire w_now  = s_axi_wvalid && s_axi_wready;
  wire aw_ok  = aw_have_reg || aw_now;
  wire w_ok   = w_have_reg || w_now;
  wire [7:0]  wa = aw_have_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_have_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  ws = w_have_reg ? wstrb_reg : s_axi_wstrb;
  wire do_wr  = aw_ok && w_ok && !s_axi_bvalid;
  wire wr_ok  = (wa[7:4] == `OFS_IRQ_CTRL) || (wa == `OFS_IRQ_REG) || (wa == `OFS_TIMER_REG);
  wire wr_c0  = do_wr && ws[0] && (wa == {4'h0, `OFS_CONTROL_0});
  wire wr_c1  = do_wr && ws[0] && (wa == {4'h0, `OFS_CONTROL_1});
  wire wr_rh  = do_wr && ws[0] && (wa == {4'h0, `OFS_RESULT_HIGH});
  wire wr_rl  = do_wr && ws[0] && (wa == {4'h0, `OFS_RESULT_LOW});
  wire wr_irq = do_wr && ws[0] && (wa == `OFS_IRQ_REG);
  wire wr_tmr = do_wr && (wa == `OFS_TIMER_REG);

  // software clearing go/done while a conversion runs
  wire sw_abort  = wr_c0 && !wd[`BIT_GO_DONE] && go_done;
  wire sw_go     = wr_c0 && wd[`BIT_GO_DONE] && !go_done && converter_on;
  wire hw_go     = special_trigger && converter_on && !go_done;
  wire sleep_kill = sleep_reg && !rc_clock && (busy || pend_reg);
  wire start_req = sw_go || hw_go;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_0_reg        <= `RESET_BYTE;
      control_1_reg        <= `RESET_BYTE;
      result_high_byte_reg <= `RESET_BYTE;
      result_low_byte_reg  <= `RESET_BYTE;
      done_flag_reg        <= 1'b0;
      irq_en_reg           <= 1'b0;
      periph_en_reg        <= 1'b0;
      global_en_reg        <= 1'b0;
      timer_reg            <= `RESET_TIMER;
      off_reg              <= 1'b0;
      delay_reg            <= 4'h0;
      pend_reg             <= 1'b0;
    end
    else if (ce)
    begin
      timer_reg <= timer_reg + 16'h0001;
      if (wr_tmr)
        timer_reg <= wd[15:0];
      if (hw_go)
        timer_reg <= `RESET_TIMER;
      if (wr_c0)
      begin
        control_0_reg <= (wd[7:0] & `CONTROL_0_MASK & ~(8'h01 << `BIT_GO_DONE))
                         | ({7'h00, go_done && wd[`BIT_GO_DONE]} << `BIT_GO_DONE);
        if (wd[`BIT_CONVERTER_ON] && !converter_on)
          off_reg <= 1'b0;
      end
      if (wr_c1)
        control_1_reg <= wd[7:0] & `CONTROL_1_MASK;
      if (wr_rh)
        result_high_byte_reg <= wd[7:0];
      if (wr_rl)
        result_low_byte_reg <= wd[7:0];
      if (wr_irq)
      begin
        irq_en_reg    <= wd[`BIT_IRQ_EN];
        periph_en_reg <= wd[`BIT_PERIPH_EN];
        global_en_reg <= wd[`BIT_GLOBAL_EN];
        if (!wd[`BIT_DONE_FLAG])
          done_flag_reg <= 1'b0;
      end
      if (start_req)
      begin
        control_0_reg[`BIT_GO_DONE] <= 1'b1;
        pend_reg  <= 1'b1;
        off_reg   <= 1'b0;
        delay_reg <= rc_clock ? `RC_DELAY_CYCLES : 4'h0;
      end
      else if (pend_reg && !sleep_kill)
      begin
        if (delay_reg != 4'h0)
          delay_reg <= delay_reg - 4'h1;
        else
          pend_reg <= 1'b0;
      end
      if (sleep_kill)
      begin
        pend_reg                    <= 1'b0;
        off_reg                     <= 1'b1;
        control_0_reg[`BIT_GO_DONE] <= 1'b0;
      end
      if (done && !sleep_kill && active)
      begin
        control_0_reg[`BIT_GO_DONE] <= 1'b0;
        done_flag_reg               <= 1'b1;
        if (control_1_reg[`BIT_RIGHT_JUST])
        begin
          result_high_byte_reg <= {6'h00, code[9:8]};
          result_low_byte_reg  <= code[7:0];
        end
        else
        begin
          result_high_byte_reg <= code[9:2];
          result_low_byte_reg  <= {code[1:0], 6'h00};
        end
        if (sleep_reg && !irq_en_reg)
          off_reg <= 1'b1;
      end
    end
  end

  sar_core #(
    .WIDTH (WIDTH),
    .TAD   (TAD)
  ) core (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .start     (pend_reg && delay_reg == 4'h0 && active && !sleep_kill && go_done),
    .abort     (sw_abort || sleep_kill || !active),
    .comp_in   (comp_reg),
    .trial_reg (trial),
    .code_reg  (code),
    .busy_reg  (busy),
    .done_reg  (done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      powered        <= 1'b0;
      channel_select <= 5'h00;
      dac_trial      <= 10'h000;
      irq            <= 1'b0;
      wake           <= 1'b0;
    end
    else if (ce)
    begin
      powered        <= active;
      channel_select <= control_0_reg[`BIT_CHS_HI:`BIT_CHS_LO];
      dac_trial      <= trial;
      irq            <= done_flag_reg && irq_en_reg && periph_en_reg && global_en_reg;
      wake           <= done && sleep_reg && irq_en_reg && active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data may arrive in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= `RESET_WORD;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= `RESET_WORD;
      wstrb_reg     <= 4'h0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_ok && !s_axi_awready;
      s_axi_wready  <= !w_ok && !s_axi_wready;
      if (aw_now)
      begin
        awaddr_reg  <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (w_now)
      begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (do_wr)
      begin
        aw_have_reg   <= 1'b0;
        w_have_reg    <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          {4'h0, `OFS_CONTROL_0}:   s_axi_rdata <= reg_word(control_0_reg);
          {4'h0, `OFS_CONTROL_1}:   s_axi_rdata <= reg_word(control_1_reg);
          {4'h0, `OFS_RESULT_HIGH}: s_axi_rdata <= reg_word(result_high_byte_reg);
          {4'h0, `OFS_RESULT_LOW}:  s_axi_rdata <= reg_word(result_low_byte_reg);
          `OFS_IRQ_REG:             s_axi_rdata <= reg_word({3'h0, sleep_reg, global_en_reg,
                                                   periph_en_reg, irq_en_reg, done_flag_reg});
          `OFS_TIMER_REG:           s_axi_rdata <= {16'h0000, timer_reg};
          default:
          begin
            s_axi_rdata <= `RESET_WORD;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### adc_conversion_sequencer_tb.sv
/*
 self-checking bench for the converter sequencer: bus master tasks, read notes
 queued and checked by a watcher, conversion, abort, sleep, trigger and reset runs.
 assumes: comparator held constant per conversion so every trial bit resolves alike.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module adc_conversion_sequencer_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        comp_in = 1'b0;
  logic        sleep_in = 1'b0;
  logic        special_trigger = 1'b0;
  wire logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic       powered, irq, wake;
  wire logic [4:0] channel_select;
  wire logic [9:0] dac_trial;
  int          mismatches = 0;
  int          checks_done = 0;
  int          wake_cnt = 0;
  int          i, w0;
  logic [65:0] notes[$];
  logic [65:0] nt;
  logic [31:0] seed = 32'h99da;
  logic [31:0] q;
  logic [4:0]  ch;
  logic        cv;
  adc_conversion_sequencer #(.WIDTH(10), .TAD(4)) uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .comp_in, .sleep_in, .special_trigger, .powered, .channel_select, .dac_trial, .irq, .wake);
  always #50 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task automatic finish_test;
    begin
      $display("comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task automatic timeout;
    begin
      mismatches++;
      finish_test();
    end
  endtask
  // leading edge keeps a new request from landing in the step that released the last one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      for (n = 0; n < 40 && !hb; n++)
      begin
        @(negedge aclk);
        ha = s_axi_awvalid & s_axi_awready;
        hw = s_axi_wvalid & s_axi_wready;
        hb = s_axi_bvalid;
        if (hb) `CHK("bresp", `RESP_OKAY, s_axi_bresp)
        @(posedge aclk);
        if (ha) s_axi_awvalid <= 1'b0;
        if (hw) s_axi_wvalid <= 1'b0;
        if (hb) s_axi_bready <= 1'b0;
      end
      if (!hb) timeout();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m, output logic [31:0] d);
    int n;
    logic ha, hr;
    begin
      @(posedge aclk);
      notes.push_back({e, m});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hr = 1'b0;
      for (n = 0; n < 40 && !hr; n++)
      begin
        @(negedge aclk);
        ha = s_axi_arvalid & s_axi_arready;
        hr = s_axi_rvalid;
        d = s_axi_rdata;
        @(posedge aclk);
        if (ha) s_axi_arvalid <= 1'b0;
        if (hr) s_axi_rready <= 1'b0;
      end
      if (!hr) timeout();
    end
  endtask
  task automatic rx(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    rd(a, {`RESP_OKAY, d}, 32'hffff_ffff, x);
  endtask
  task automatic wait_idle;
    int n;
    logic [31:0] x;
    begin
      x = 32'h2;
      for (n = 0; n < 60 && x[1] !== 1'b0; n++)
        rd(8'h00, 34'h0, 32'h0, x);
      if (x[1] !== 1'b0) timeout();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (s_axi_rvalid && s_axi_rready)
    begin
      nt = notes.pop_front();
      `CHK("rresp", nt[65:64], s_axi_rresp)
      `CHK("rdata", nt[63:32] & nt[31:0], s_axi_rdata & nt[31:0])
    end
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++) rx(8'(4 * i), 32'h0);
    rd(8'h18, {`RESP_SLVERR, 32'h0}, 32'hffff_ffff, q);
    wr(8'h00, 32'h2);
    rx(8'h00, 32'h0);
    rx(8'h08, 32'h0);
    wr(8'h00, 32'h3);
    rx(8'h00, 32'h1);
    seed = xs(seed);
    cv = seed[0];
    ch = seed[7:3];
    comp_in <= cv;
    wr(8'h00, {25'h0, ch, 2'b01});
    wr(8'h00, {25'h0, ch, 2'b11});
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    wait_idle();
    `CHK("channel", ch, channel_select)
    rx(8'h08, {24'h0, {8{cv}}});
    rx(8'h0c, {24'h0, cv, cv, 6'h0});
    for (i = 0; i < 8; i++)
    begin
      wr(8'h10, {28'h0, i[2:0], 1'b1});
      repeat (3) @(posedge aclk);
      `CHK("irq", &i[2:0], irq)
    end
    wr(8'h10, 32'h0);
    rx(8'h10, 32'h0);
    comp_in <= ~cv;
    wr(8'h04, 32'h80);
    wr(8'h00, 32'h3);
    repeat (14) @(posedge aclk);
    wr(8'h00, 32'h1);
    rx(8'h00, 32'h1);
    rx(8'h08, {30'h0, ~cv, ~cv});
    rx(8'h0c, {24'h0, {8{~cv}}});
    wr(8'h14, 32'h8000);
    special_trigger <= 1'b1;
    @(posedge aclk);
    special_trigger <= 1'b0;
    rx(8'h00, 32'h3);
    rd(8'h14, 34'h0, 32'h0, q);
    `CHK("timer cleared", 1'b1, q < 32'h40)
    wait_idle();
    wr(8'h00, 32'h3);
    repeat (8) @(posedge aclk);
    sleep_in <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK("powered", 1'b0, powered)
    rx(8'h00, 32'h1);
    rx(8'h0c, {24'h0, {8{~cv}}});
    sleep_in <= 1'b0;
    wr(8'h04, 32'h30);
    wr(8'h10, 32'h2);
    w0 = wake_cnt;
    wr(8'h00, 32'h3);
    sleep_in <= 1'b1;
    wait_idle();
    `CHK("wake count", w0 + 1, wake_cnt)
    `CHK("powered", 1'b1, powered)
    rx(8'h10, 32'h13);
    sleep_in <= 1'b0;
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h3);
    sleep_in <= 1'b1;
    wait_idle();
    `CHK("powered", 1'b0, powered)
    `CHK("wake count", w0 + 1, wake_cnt)
    rx(8'h00, 32'h1);
    sleep_in <= 1'b0;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("powered", 1'b0, powered)
    rx(8'h00, 32'h0);
    rx(8'h10, 32'h0);
    repeat (3) @(posedge aclk);
    finish_test();
  end
endmodule
`default_nettype wire

// ### adc_seq_consts.vh
/*
 constants for the converter sequencer: register offsets, bit positions,
 reset values, clock selections and timing counts.
 assumes: included by the sequencer design files and by the sequencer testbench.
*/
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

`define OFS_CONTROL_0    4'h0
`define OFS_CONTROL_1    4'h4
`define OFS_RESULT_HIGH  4'h8
`define OFS_RESULT_LOW   4'hc
`define OFS_IRQ_CTRL     4'h0
`define OFS_IRQ_REG      8'h10
`define OFS_TIMER_REG    8'h14

`define BIT_CONVERTER_ON 0
`define BIT_GO_DONE      1
`define BIT_CHS_LO       2
`define BIT_CHS_HI       6
`define BIT_RIGHT_JUST   7
`define BIT_CLK_LO       4
`define BIT_CLK_HI       6
`define BIT_DONE_FLAG    0
`define BIT_IRQ_EN       1
`define BIT_PERIPH_EN    2
`define BIT_GLOBAL_EN    3
`define BIT_SLEEPING     4

`define CLKSEL_RC        3'h3
`define CLKSEL_RC_ALT    3'h7
`define CONTROL_0_MASK   8'h7f
`define CONTROL_1_MASK   8'hf3
`define IRQ_WR_MASK      8'h0f
`define RESET_BYTE       8'h00
`define RESET_WORD       32'h0000_0000
`define RESET_TIMER      16'h0000

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define RC_DELAY_CYCLES  4'h4
`define TAD_CYCLES_DEF   4

`endif

// ### adc_seq_monitor.sv
/*
 checker for the converter sequencer: bus answers, reset state and output relations.
 assumes: bound to the sequencer top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor #(
  parameter WIDTH = 10,
  parameter TAD   = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        powered,
  input wire logic [9:0]  dac_trial,
  input wire logic        irq,
  input wire logic        wake
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // reset is the antecedent here, so this one must not be disabled by it
  reset_clears_all_a: assert property (disable iff (1'b0) !aresetn |=>
    !powered && !irq && !wake && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  write_answer_a: assert property ($rose(s_axi_awvalid) && s_axi_wvalid |-> ##[1:5] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  wake_one_cycle_a: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  idle_trial_frozen_a: assert property (!powered && !$past(powered) && !$past(powered, 2) |->
    $stable(dac_trial))
    else $error("trial word moves while converter is off");
  ce_freezes_state_a: assert property (!ce |=> $stable(powered) && $stable(dac_trial))
    else $error("state moved with clock enable low");
endmodule
bind adc_conversion_sequencer adc_seq_monitor #(.WIDTH(WIDTH), .TAD(TAD)) mon (.aclk, .aresetn, .ce, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .powered, .dac_trial, .irq, .wake);
`default_nettype wire

// ### sar_core.v
/*
 successive-approximation core: resolves one bit per step from msb down.
 assumes: a comparator input from the analog side, sampled on aclk; abort gives
 the partial code with unresolved bits copied from the last resolved one.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module sar_core #(
  parameter WIDTH = 10,
  parameter TAD   = `TAD_CYCLES_DEF
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             ce,
  input  wire             start,
  input  wire             abort,
  input  wire             comp_in,
  output reg  [WIDTH-1:0] trial_reg,
  output reg  [WIDTH-1:0] code_reg,
  output reg              busy_reg,
  output reg              done_reg
);

  reg [WIDTH-1:0] code_next;
  reg [WIDTH-1:0] bit_reg;
  reg [7:0]       tad_reg;
  integer         i;

  // fill every unresolved position with the last resolved bit
  always @*
  begin
    code_next = trial_reg;
    for (i = WIDTH - 2; i >= 0; i = i - 1)
      if (bit_reg[i] || (bit_reg > {{(WIDTH-1){1'b0}}, 1'b1} << i))
        code_next[i] = (i == WIDTH - 1) ? trial_reg[i] : code_next[i+1];
    if (bit_reg[WIDTH-1])
      code_next = {WIDTH{1'b0}};
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trial_reg <= {WIDTH{1'b0}};
      code_reg  <= {WIDTH{1'b0}};
      bit_reg   <= {WIDTH{1'b0}};
      tad_reg   <= 8'h00;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end
    else if (ce)
    begin
      done_reg <= 1'b0;
      if (start && !busy_reg)
      begin
        busy_reg  <= 1'b1;
        bit_reg   <= {1'b1, {(WIDTH-1){1'b0}}};
        trial_reg <= {WIDTH{1'b0}};
        tad_reg   <= 8'h00;
      end
      else if (busy_reg && abort)
      begin
        busy_reg <= 1'b0;
        code_reg <= code_next;
        done_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        if (tad_reg == TAD[7:0] - 8'h01)
        begin
          tad_reg   <= 8'h00;
          trial_reg <= trial_reg | (comp_in ? bit_reg : {WIDTH{1'b0}});
          bit_reg   <= bit_reg >> 1;
          if (bit_reg[0])
          begin
            busy_reg <= 1'b0;
            code_reg <= trial_reg | (comp_in ? bit_reg : {WIDTH{1'b0}});
            done_reg <= 1'b1;
          end
        end
        else
          tad_reg <= tad_reg + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire
